// file: hw/adc_cal_pkg.sv
// Shared constants, types and helpers for the calibration access block
// Notes on behaviour
// - Launch with self kind: code picks DAC-gain-offset, gain-offset, offset, or gain.
// - Launch with system kind: same codes pick the system calibration steps.
// - Status word is 16-bit read-only, selected by readback select 11.
// - Every stored status field reads zero after power-up until changed.
// - Status bits 15 and 14 read zero, bits 7 and 6 read one.
// - Bit 13 shows single-ended select, bits 12..10 show input pair select.
// - Bits 9 and 8 show the two power-down configuration bits.
// - Bit 5 shows the analog range mode bit.
// - Bit 4 is one while a conversion or calibration runs.
// - Bit 3 shows calibration kind, bits 2 and 1 the target-select code.
// - Bit 0 is one while a calibration runs.
// - Ten coefficient registers: eight DAC, offset, gain; all writable and readable.
// - Calibrations update the coefficient registers on their own.
// - Target code sets the register set: ten, gain+offset, offset, gain.
// - Pointer returns to sequence start on control write or sequence end.
// - After reset pointer is at gain, except offset-only selects offset.
// - Pointer advances per full access; in byte mode after the high byte.
// - Host may abandon a sequence; next control write resets pointer.
// - Coefficient values read back carry two leading zero bits.
// - With launch at zero, target code addresses the coefficient registers.
// - Readback select bits pick the register returned on reads.
package adc_cal_pkg;

  localparam int DATA_W   = 16;
  localparam int COEF_W   = 14;
  localparam int NUM_COEF = 10;
  localparam int IDX_W    = 4;

  // Control word and status word bit positions
  localparam int CT_SGL     = 13;
  localparam int CT_CH_LSB  = 10;
  localparam int CT_PM_LSB  = 8;
  localparam int CT_RB_LSB  = 6;
  localparam int CT_ANALOG_RANGE_MODE   = 5;
  localparam int CT_CONV    = 4;
  localparam int CT_KIND    = 3;
  localparam int CT_TGT_LSB = 1;
  localparam int CT_LAUNCH  = 0;
  localparam int ST_ONE_LSB = 6;
  localparam int ST_BUSY    = 4;
  localparam int ST_RUN     = 0;
  localparam logic [1:0] ST_ONES = 2'h3;

  localparam logic [1:0] RB_CONV   = 2'h0;
  localparam logic [1:0] RB_AUX    = 2'h1;
  localparam logic [1:0] RB_COEF   = 2'h2;
  localparam logic [1:0] RB_STATUS = 2'h3;

  localparam logic [1:0] TGT_FULL      = 2'h0;
  localparam logic [1:0] TGT_GAIN_OFFS = 2'h1;
  localparam logic [1:0] TGT_OFFS      = 2'h2;
  localparam logic [1:0] TGT_GAIN      = 2'h3;

  localparam logic [IDX_W-1:0] IDX_GAIN  = 4'h0;
  localparam logic [IDX_W-1:0] IDX_OFFS  = 4'h1;
  localparam logic [IDX_W-1:0] LAST_FULL = 4'h9;
  localparam logic [IDX_W-1:0] LAST_PAIR = 4'h1;
  localparam logic [IDX_W-1:0] LAST_ONE  = 4'h0;

  localparam logic WA_CTRL = 1'b0;
  localparam logic WA_COEF = 1'b1;

  typedef struct packed {
    logic       single_ended_select;
    logic [2:0] input_pair_sel;
    logic [1:0] power_down_cfg;
    logic [1:0] readback_sel;
    logic       analog_range_mode;
    logic       calibration_kind_select;
    logic [1:0] cal_target_sel;
  } ctrl_t;

  typedef struct packed {
    logic system_cal;
    logic dac_step;
    logic gain_step;
    logic offset_step;
  } cal_type_t;

  typedef enum logic [0:0] {
    CAL_IDLE = 1'b0,
    CAL_RUN  = 1'b1
  } cal_phase_t;

  typedef struct packed {
    ctrl_t             ctrl;
    cal_phase_t        phase;
    logic [7:0]        lo_stage;
    logic [IDX_W-1:0]  pos;
    logic [DATA_W-1:0] dout;
    logic              conv_start;
    logic              cal_start;
    cal_type_t         cal_type;
  } top_state_t;

  localparam top_state_t STATE_RST = '0;

  // Last position of the sequence that a target code selects
  // register set size minus one
  function automatic logic [IDX_W-1:0] seq_last(input logic [1:0] tgt);
    unique case (tgt)
      TGT_FULL:      seq_last = LAST_FULL;
      TGT_GAIN_OFFS: seq_last = LAST_PAIR;
      default:       seq_last = LAST_ONE;
    endcase
  endfunction

  // Coefficient index at a sequence position
  function automatic logic [IDX_W-1:0] seq_index(input logic [1:0] tgt,
                                                input logic [IDX_W-1:0] pos);
    seq_index = (tgt == TGT_OFFS) ? IDX_OFFS : pos;
  endfunction

endpackage

// file: hw/adc_coef_store.sv
// Coefficient storage with registered, write-through read data
`timescale 1ns/10ps
`default_nettype none
module adc_coef_store #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 10,
  parameter int AW    = 4
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             we_i,
  input  wire logic [AW-1:0]    waddr_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  input  wire logic [AW-1:0]    raddr_i,
  output logic      [WIDTH-1:0] rdata_o
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
      rdata_o <= '0;
    end else begin
      if (we_i) begin
        mem[waddr_i] <= wdata_i;
      end
      rdata_o <= (we_i && waddr_i == raddr_i) ? wdata_i : mem[raddr_i];
    end
  end

endmodule
`default_nettype wire

// file: hw/adc_cal_decode.sv
// Decoder from calibration kind and target code to calibration steps
`timescale 1ns/10ps
`default_nettype none
module adc_cal_decode (
  input  wire logic                  kind_i,
  input  wire logic [1:0]            tgt_i,
  output adc_cal_pkg::cal_type_t     type_o
);
  import adc_cal_pkg::*;

  always_comb begin
    type_o.system_cal = kind_i;
    unique case (tgt_i)
      TGT_FULL:      {type_o.dac_step, type_o.gain_step,
                      type_o.offset_step} = 3'h7;
      TGT_GAIN_OFFS: {type_o.dac_step, type_o.gain_step,
                      type_o.offset_step} = 3'h3;
      TGT_OFFS:      {type_o.dac_step, type_o.gain_step,
                      type_o.offset_step} = 3'h1;
      TGT_GAIN:      {type_o.dac_step, type_o.gain_step,
                      type_o.offset_step} = 3'h2;
    endcase
  end

endmodule
`default_nettype wire

// file: hw/adc_cal_access.sv
// Control decode, status word and coefficient pointer of the converter
`timescale 1ns/10ps
`default_nettype none
module adc_cal_access (
  input  wire logic                            CLK_I,
  input  wire logic                            RST_I,
  input  wire logic                            WR_STB_I,
  input  wire logic                            WR_ADDR_I,
  input  wire logic                            RD_STB_I,
  input  wire logic                            BYTE_MODE_I,
  input  wire logic                            HIGH_BYTE_SELECT_I,
  input  wire logic [adc_cal_pkg::DATA_W-1:0]  DATA_I,
  input  wire logic [adc_cal_pkg::DATA_W-1:0]  CONV_RESULT_I,
  input  wire logic                            CONV_BUSY_I,
  input  wire logic                            CAL_DONE_I,
  input  wire logic                            CAL_COEF_WE_I,
  input  wire logic [adc_cal_pkg::IDX_W-1:0]   CAL_COEF_IDX_I,
  input  wire logic [adc_cal_pkg::COEF_W-1:0]  CAL_COEF_DATA_I,
  output logic      [adc_cal_pkg::DATA_W-1:0]  DATA_O,
  output adc_cal_pkg::ctrl_t                   CTRL_O,
  output logic                                 CONV_START_O,
  output logic                                 CAL_START_O,
  output adc_cal_pkg::cal_type_t               CAL_TYPE_O,
  output logic                                 CAL_RUNNING_O
);
  import adc_cal_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------

  top_state_t        state;
  top_state_t        next_state;
  logic [DATA_W-1:0] wword;
  logic              ctrl_commit;
  logic              coef_commit;
  logic              coef_read;
  logic              advance;
  logic              running;
  logic              busy;
  logic              lo_write;
  logic [DATA_W-1:0] status_word;
  logic [DATA_W-1:0] read_word;
  logic [DATA_W-1:0] read_bytes;
  logic [IDX_W-1:0]  coef_raddr;
  logic [IDX_W-1:0]  mem_waddr;
  logic [COEF_W-1:0] mem_wdata;
  logic [COEF_W-1:0] mem_rdata;
  logic              mem_we;
  cal_type_t         launch_type;

  // ----------------------------------------------------------------
  // Access qualification
  // ----------------------------------------------------------------

  assign running = (state.phase == CAL_RUN);
  assign busy    = CONV_BUSY_I | running;

  // Byte mode stages the low byte; the high-byte write completes the word
  assign lo_write = WR_STB_I && BYTE_MODE_I && !HIGH_BYTE_SELECT_I;
  assign wword    = BYTE_MODE_I ? {DATA_I[7:0], state.lo_stage} : DATA_I;

  assign ctrl_commit = WR_STB_I && (WR_ADDR_I == WA_CTRL)
                       && (!BYTE_MODE_I || HIGH_BYTE_SELECT_I);
  assign coef_commit = WR_STB_I && (WR_ADDR_I == WA_COEF)
                       && (!BYTE_MODE_I || HIGH_BYTE_SELECT_I);

  assign coef_read = RD_STB_I && (state.ctrl.readback_sel == RB_COEF)
                     && (!BYTE_MODE_I || HIGH_BYTE_SELECT_I);
  assign advance   = coef_commit || coef_read;

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------

  always_comb begin
    status_word                      = '0;
    status_word[ST_ONE_LSB +: 2]     = ST_ONES;
    status_word[CT_SGL]              = state.ctrl.single_ended_select;
    status_word[CT_CH_LSB +: 3]      = state.ctrl.input_pair_sel;
    status_word[CT_PM_LSB +: 2]      = state.ctrl.power_down_cfg;
    status_word[CT_ANALOG_RANGE_MODE]            = state.ctrl.analog_range_mode;
    status_word[ST_BUSY]             = busy;
    status_word[CT_KIND]             = state.ctrl.calibration_kind_select;
    status_word[CT_TGT_LSB +: 2]     = state.ctrl.cal_target_sel;
    status_word[ST_RUN]              = running;
  end

  // ----------------------------------------------------------------
  // Read data selection
  // ----------------------------------------------------------------

  always_comb begin
    unique case (state.ctrl.readback_sel)
      RB_CONV:   read_word = CONV_RESULT_I;
      RB_AUX:    read_word = '0;
      RB_COEF:   read_word = {2'h0, mem_rdata};
      RB_STATUS: read_word = status_word;
    endcase
    if (BYTE_MODE_I) begin
      read_bytes = HIGH_BYTE_SELECT_I ? {8'h00, read_word[15:8]}
                                      : {8'h00, read_word[7:0]};
    end else begin
      read_bytes = read_word;
    end
  end

  // ----------------------------------------------------------------
  // Calibration type decode
  // ----------------------------------------------------------------

  adc_cal_decode u_decode (
    .kind_i (wword[CT_KIND]),
    .tgt_i  (wword[CT_TGT_LSB +: 2]),
    .type_o (launch_type)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------

  always_comb begin
    next_state            = state;
    next_state.conv_start = 1'b0;
    next_state.cal_start  = 1'b0;

    if (running && CAL_DONE_I) begin
      next_state.phase = CAL_IDLE;
    end

    if (lo_write) begin
      next_state.lo_stage = DATA_I[7:0];
    end

    if (RD_STB_I) begin
      next_state.dout = read_bytes;
    end

    if (advance) begin
      if (state.pos >= seq_last(state.ctrl.cal_target_sel)) begin
        next_state.pos = '0;
      end else begin
        next_state.pos = state.pos + 4'h1;
      end
    end

    if (ctrl_commit) begin
      next_state.ctrl.single_ended_select     = wword[CT_SGL];
      next_state.ctrl.input_pair_sel          = wword[CT_CH_LSB +: 3];
      next_state.ctrl.power_down_cfg          = wword[CT_PM_LSB +: 2];
      next_state.ctrl.readback_sel            = wword[CT_RB_LSB +: 2];
      next_state.ctrl.analog_range_mode       = wword[CT_ANALOG_RANGE_MODE];
      next_state.ctrl.calibration_kind_select = wword[CT_KIND];
      next_state.ctrl.cal_target_sel          = wword[CT_TGT_LSB +: 2];
      next_state.pos        = '0;
      next_state.conv_start = wword[CT_CONV];
      if (wword[CT_LAUNCH] && !running) begin
        next_state.phase     = CAL_RUN;
        next_state.cal_start = 1'b1;
        next_state.cal_type  = launch_type;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state <= STATE_RST;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Coefficient storage
  // ----------------------------------------------------------------

  assign coef_raddr = seq_index(next_state.ctrl.cal_target_sel,
                                next_state.pos);

  assign mem_we    = CAL_COEF_WE_I || coef_commit;
  assign mem_waddr = CAL_COEF_WE_I ? CAL_COEF_IDX_I
                     : seq_index(state.ctrl.cal_target_sel, state.pos);
  assign mem_wdata = CAL_COEF_WE_I ? CAL_COEF_DATA_I
                     : wword[COEF_W-1:0];

  adc_coef_store #(
    .WIDTH (COEF_W),
    .DEPTH (NUM_COEF),
    .AW    (IDX_W)
  ) u_store (
    .clk_i   (CLK_I),
    .rst_i   (RST_I),
    .we_i    (mem_we),
    .waddr_i (mem_waddr),
    .wdata_i (mem_wdata),
    .raddr_i (coef_raddr),
    .rdata_o (mem_rdata)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  assign DATA_O        = state.dout;
  assign CTRL_O        = state.ctrl;
  assign CONV_START_O  = state.conv_start;
  assign CAL_START_O   = state.cal_start;
  assign CAL_TYPE_O    = state.cal_type;
  assign CAL_RUNNING_O = running;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);

  logic status_rd;
  logic coef_rd_word;
  assign status_rd    = RD_STB_I && !BYTE_MODE_I
                        && (state.ctrl.readback_sel == RB_STATUS);
  assign coef_rd_word = RD_STB_I && !BYTE_MODE_I
                        && (state.ctrl.readback_sel == RB_COEF);

  property p_status_fixed;
    status_rd |=> (DATA_O[15:14] == 2'h0) && (DATA_O[7:6] == 2'h3);
  endproperty
  a_status_fixed: assert property (p_status_fixed)
    else $error("status fixed bits wrong");

  property p_status_busy;
    status_rd |=> DATA_O[ST_BUSY] == $past(busy);
  endproperty
  a_status_busy: assert property (p_status_busy)
    else $error("status busy bit wrong");

  property p_status_run;
    status_rd |=> DATA_O[ST_RUN] == $past(running);
  endproperty
  a_status_run: assert property (p_status_run)
    else $error("status run bit wrong");

  property p_ptr_restart;
    ctrl_commit |=> state.pos == 4'h0;
  endproperty
  a_ptr_restart: assert property (p_ptr_restart)
    else $error("pointer not restarted by control write");

  property p_ptr_wrap;
    (advance && !ctrl_commit && state.ctrl.cal_target_sel == TGT_FULL
      && state.pos == LAST_FULL) |=> state.pos == 4'h0;
  endproperty
  a_ptr_wrap: assert property (p_ptr_wrap)
    else $error("pointer did not wrap after last register");

  property p_ptr_low_byte;
    (RD_STB_I && BYTE_MODE_I && !HIGH_BYTE_SELECT_I && !WR_STB_I)
      |=> $stable(state.pos);
  endproperty
  a_ptr_low_byte: assert property (p_ptr_low_byte)
    else $error("pointer moved on low byte access");

  property p_offs_only;
    state.ctrl.cal_target_sel == TGT_OFFS |-> coef_raddr == IDX_OFFS
      || next_state.ctrl.cal_target_sel != TGT_OFFS;
  endproperty
  a_offs_only: assert property (p_offs_only)
    else $error("offset-only pointer not on offset register");

  property p_coef_zeros;
    coef_rd_word |=> DATA_O[15:14] == 2'h0;
  endproperty
  a_coef_zeros: assert property (p_coef_zeros)
    else $error("coefficient readback lacks leading zeros");

  property p_launch_full;
    (ctrl_commit && wword[CT_LAUNCH] && !running
      && wword[CT_TGT_LSB +: 2] == TGT_FULL)
      |=> CAL_START_O && CAL_RUNNING_O && (CAL_TYPE_O[2:0] == 3'h7)
          ##1 !CAL_START_O;
  endproperty
  a_launch_full: assert property (p_launch_full)
    else $error("full calibration launch wrong");

  property p_launch_refused;
    (ctrl_commit && wword[CT_LAUNCH] && running)
      |=> !CAL_START_O && $stable(CAL_TYPE_O);
  endproperty
  a_launch_refused: assert property (p_launch_refused)
    else $error("launch accepted while calibration running");

  property p_cal_end;
    (running && CAL_DONE_I) |=> !CAL_RUNNING_O;
  endproperty
  a_cal_end: assert property (p_cal_end)
    else $error("calibration still running after done");

  property p_ctrl_fields;
    ctrl_commit |=> (CTRL_O.cal_target_sel == $past(wword[CT_TGT_LSB +: 2]))
      && (CTRL_O.readback_sel == $past(wword[CT_RB_LSB +: 2]));
  endproperty
  a_ctrl_fields: assert property (p_ctrl_fields)
    else $error("control write not stored");

  property p_lo_stage_only;
    (lo_write && !RD_STB_I) |=> $stable(state.pos) && $stable(state.ctrl);
  endproperty
  a_lo_stage_only: assert property (p_lo_stage_only)
    else $error("low byte write changed pointer or control");

  property p_status_inputs;
    status_rd |=> DATA_O[CT_SGL:CT_PM_LSB]
      == $past({state.ctrl.single_ended_select, state.ctrl.input_pair_sel,
                state.ctrl.power_down_cfg});
  endproperty
  a_status_inputs: assert property (p_status_inputs)
    else $error("status input selection bits wrong");

  c_status_read: cover property (status_rd ##1 DATA_O[ST_BUSY]);
  c_full_seq:    cover property (advance && state.pos == LAST_FULL);
  c_cal_done:    cover property (running && CAL_DONE_I);
  c_offs_only:   cover property (coef_read
                   && state.ctrl.cal_target_sel == TGT_OFFS);
  c_byte_coef:   cover property (coef_read && BYTE_MODE_I);

endmodule
`default_nettype wire

// file: bench/adc_host_model.sv
// Host processor model driving the parallel register bus
`timescale 1ns/10ps
`default_nettype none
module adc_host_model (
  input  wire logic        clk_i,
  input  wire logic        byte_mode_i,
  input  wire logic [15:0] rdata_i,
  output logic             wr_stb_o,
  output logic             wr_addr_o,
  output logic             rd_stb_o,
  output logic             hbe_o,
  output logic [15:0]      wdata_o
);
  logic [15:0] lo;

  initial begin
    wr_stb_o = 1'b0;
    wr_addr_o = 1'b0;
    rd_stb_o = 1'b0;
    hbe_o = 1'b0;
    wdata_o = 16'h0000;
    lo = 16'h0000;
  end

  // One strobe cycle; the released data bus shows the inverse value
  task automatic cyc(input logic wr, input logic a, input logic hb,
                     input logic [15:0] d);
    @(posedge clk_i);
    #1;
    wr_stb_o = wr;
    rd_stb_o = !wr;
    wr_addr_o = a;
    hbe_o = hb;
    wdata_o = d;
    @(posedge clk_i);
    #1;
    wr_stb_o = 1'b0;
    rd_stb_o = 1'b0;
    wdata_o = ~d;
  endtask

  task automatic wr(input logic a, input logic [15:0] d);
    if (byte_mode_i) begin
      cyc(1'b1, a, 1'b0, {8'h00, d[7:0]});
      cyc(1'b1, a, 1'b1, {8'h00, d[15:8]});
    end else begin
      cyc(1'b1, a, 1'b0, d);
    end
  endtask

  task automatic rd(output logic [15:0] q, output logic clean);
    if (byte_mode_i) begin
      cyc(1'b0, 1'b0, 1'b0, ~wdata_o);
      lo = rdata_i;
      cyc(1'b0, 1'b0, 1'b1, ~wdata_o);
      q = {rdata_i[7:0], lo[7:0]};
      clean = (lo[15:8] === 8'h00) && (rdata_i[15:8] === 8'h00);
    end else begin
      cyc(1'b0, 1'b0, 1'b0, ~wdata_o);
      q = rdata_i;
      clean = 1'b1;
    end
  endtask
endmodule
`default_nettype wire

// file: bench/adc_calibration_status_access_test.sv
// Self-checking bench for the calibration access block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
  $display("wrong value t=%0t got=%h exp=%h", $time, (a), (b)); end end
module adc_calibration_status_access_test;
  import adc_cal_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        byte_mode = 1'b0;
  logic [15:0] conv_result = 16'h5a3c;
  logic        conv_busy = 1'b0;
  logic        cal_done = 1'b0;
  logic        coef_we = 1'b0;
  logic [3:0]  coef_idx = 4'h0;
  logic [13:0] coef_data = 14'h0000;
  logic        wr_stb, wr_addr, rd_stb, hbe;
  logic [15:0] wdata, rdata, q;
  logic        cl, conv_start, cal_start, cal_running;
  ctrl_t       ctrl;
  cal_type_t   cal_type;
  logic [13:0] exp_c [10];
  int          error_cnt = 0;
  int          n_tests = 0;

  always #5 clk = ~clk;

  adc_host_model host (.clk_i(clk), .byte_mode_i(byte_mode),
    .rdata_i(rdata), .wr_stb_o(wr_stb), .wr_addr_o(wr_addr),
    .rd_stb_o(rd_stb), .hbe_o(hbe), .wdata_o(wdata));

  adc_cal_access dut (.CLK_I(clk), .RST_I(rst), .WR_STB_I(wr_stb),
    .WR_ADDR_I(wr_addr), .RD_STB_I(rd_stb), .BYTE_MODE_I(byte_mode),
    .HIGH_BYTE_SELECT_I(hbe), .DATA_I(wdata),
    .CONV_RESULT_I(conv_result), .CONV_BUSY_I(conv_busy),
    .CAL_DONE_I(cal_done), .CAL_COEF_WE_I(coef_we),
    .CAL_COEF_IDX_I(coef_idx), .CAL_COEF_DATA_I(coef_data),
    .DATA_O(rdata), .CTRL_O(ctrl), .CONV_START_O(conv_start),
    .CAL_START_O(cal_start), .CAL_TYPE_O(cal_type),
    .CAL_RUNNING_O(cal_running));

  task automatic tally_and_finish;
    $display("comparisons=%0d mismatches=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic t_reset;
    `CHK(ctrl, '0)
    `CHK(cal_running, 1'b0)
    host.wr(1'b0, 16'h00c0);
    host.rd(q, cl);
    `CHK(q, 16'h00c0)
  endtask

  task automatic t_status;
    logic [15:0] w [2];
    w[0] = 16'hf6ec;
    w[1] = 16'hc9c2;
    foreach (w[i]) begin
      host.wr(1'b0, w[i]);
      `CHK(cal_start, 1'b0)
      `CHK(ctrl, {w[i][13:5], w[i][3:1]})
      host.rd(q, cl);
      `CHK(q, w[i] & 16'h3fff)
      conv_busy = 1'b1;
      host.rd(q, cl);
      `CHK(q, (w[i] & 16'h3fff) | 16'h0010)
      conv_busy = 1'b0;
    end
    host.wr(1'b0, 16'h0010);
    `CHK(conv_start, 1'b1)
    host.rd(q, cl);
    `CHK(q, conv_result)
    host.wr(1'b0, 16'h0040);
    host.rd(q, cl);
    `CHK(q, 16'h0000)
  endtask

  task automatic t_launch;
    logic [15:0] w;
    cal_type_t   e;
    for (int k = 0; k < 2; k++) begin
      for (int t = 0; t < 4; t++) begin
        w = 16'h00c1 | (16'(k) << 3) | (16'(t) << 1);
        e = {k[0], t == 0, t != 2, t != 3};
        host.wr(1'b0, w);
        `CHK(cal_start, 1'b1)
        `CHK(cal_type, e)
        host.rd(q, cl);
        `CHK(q, w | 16'h0010)
        `CHK(cal_start, 1'b0)
        host.wr(1'b0, w ^ 16'h0008);
        `CHK(cal_start, 1'b0)
        `CHK(cal_type, e)
        @(posedge clk);
        #1;
        cal_done = 1'b1;
        @(posedge clk);
        #1;
        cal_done = 1'b0;
        `CHK(cal_running, 1'b0)
        host.rd(q, cl);
        `CHK(q, (w ^ 16'h0008) & 16'hffee)
      end
    end
  endtask

  task automatic t_coef;
    logic [15:0] v;
    int          f;
    host.wr(1'b0, 16'h0000);
    for (int i = 0; i < 10; i++) begin
      v = 16'hc000 + 16'h0531 * 16'(i + 1);
      exp_c[i] = v[13:0];
      host.wr(1'b1, v);
    end
    @(posedge clk);
    #1;
    coef_we = 1'b1;
    coef_idx = 4'h9;
    coef_data = 14'h2aaa;
    @(posedge clk);
    #1;
    coef_we = 1'b0;
    exp_c[9] = 14'h2aaa;
    host.wr(1'b0, 16'h0080);
    for (int i = 0; i < 11; i++) begin
      host.rd(q, cl);
      `CHK(q, {2'b00, exp_c[i % 10]})
    end
    repeat (3) host.rd(q, cl);
    host.wr(1'b0, 16'h0080);
    host.rd(q, cl);
    `CHK(q, {2'b00, exp_c[0]})
    for (int t = 1; t < 4; t++) begin
      f = (t == 2) ? 1 : 0;
      host.wr(1'b0, 16'h0080 | (16'(t) << 1));
      host.rd(q, cl);
      `CHK(q, {2'b00, exp_c[f]})
      host.rd(q, cl);
      `CHK(q, {2'b00, exp_c[(t == 1) ? 1 : f]})
    end
  endtask

  task automatic t_byte;
    byte_mode = 1'b1;
    host.wr(1'b0, 16'h0000);
    host.wr(1'b1, 16'h1234);
    host.wr(1'b1, 16'hff0e);
    host.wr(1'b0, 16'h0080);
    host.rd(q, cl);
    `CHK(q, 16'h1234)
    `CHK(cl, 1'b1)
    host.rd(q, cl);
    `CHK(q, 16'h3f0e)
    byte_mode = 1'b0;
  endtask

  task automatic t_rerun_reset;
    host.wr(1'b0, 16'h0081);
    `CHK(cal_running, 1'b1)
    @(posedge clk);
    #1;
    rst = 1'b1;
    @(posedge clk);
    #1;
    rst = 1'b0;
    `CHK(ctrl, '0)
    `CHK(cal_running, 1'b0)
    host.wr(1'b0, 16'h00c0);
    host.rd(q, cl);
    `CHK(q, 16'h00c0)
    host.wr(1'b0, 16'h0080);
    host.rd(q, cl);
    `CHK(q, 16'h0000)
  endtask

  initial begin
    repeat (6) @(posedge clk);
    #1;
    rst = 1'b0;
    t_reset();
    t_status();
    t_launch();
    t_coef();
    t_byte();
    t_rerun_reset();
    tally_and_finish();
  end

  initial begin
    #100000;
    error_cnt++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
